// ### iopdc_link_master.sv
// link-side model of the bus controller: frames bytes on its own clock
// assumes its tasks are called one at a time
module iopdc_link_master (
  output logic       linkClk,
  output logic       frameStart,
  output logic       byteValid,
  output logic [7:0] byteData
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    linkClk    = 1'b0;
    frameStart = 1'b0;
    byteValid  = 1'b0;
    byteData   = 8'h5a;
  end
  // clock runs only inside this task; idle data toggles
  task automatic run(input int n);
    repeat (n) begin
      #62 linkClk = 1'b1;
      #63 linkClk = 1'b0;
      byteValid  = 1'b0;
      frameStart = 1'b0;
      byteData   = ~byteData;
    end
  endtask : run
  // pointer, msb, lsb; cut after n bytes; clock kept for the fetch
  task automatic frame(input logic [23:0] w, input int n);
    #37 run(2);
    frameStart = 1'b1;
    run(1);
    for (int i = 0; i < n; i++) begin
      byteValid = 1'b1;
      byteData  = w[23-8*i -: 8];
      run(1);
    end
    run(8);
  endtask : frame
endmodule : iopdc_link_master

// ### iopdc_pin_config.sv
// eight-pin digital configuration: link-side byte capture and pin control
// assumes bytes arrive one per linkClk edge from a serial protocol engine;
// linkClk is unrelated to ref_clk and may stop between frames
module iopdc_pin_config (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        linkClk,
  input  wire logic        frameStart,
  input  wire logic        byteValid,
  input  wire logic [7:0]  byteData,
  output logic      [15:0] readWord,
  input  wire logic [7:0]  pinIn,
  output logic      [7:0]  pinOut,
  output logic      [7:0]  pinOutEnN,
  output logic      [7:0]  pullDownEn,
  output logic      [7:0]  dacChannelOn,
  output logic             refOn,
  output logic             adcOff
);

  // ==========================================================================
  // link-domain state
  typedef struct packed {
    logic                  rstS1;
    logic                  rstS2;
    iopdc_pkg::iopdc_phase_t phase;
    logic [7:0]            ptr;
    logic [7:0]            msb;
    iopdc_pkg::iopdc_wr_t  wrWord;
    logic                  wrTog;
    logic                  rdTog;
    logic [2:0]            ackS;
    logic [15:0]           readWord;
  } iopdc_link_t;

  // ==========================================================================
  // core-domain state
  typedef struct packed {
    iopdc_pkg::iopdc_cfg_t cfg;
    logic [7:0]            inS1;
    logic [7:0]            inS2;
    logic [2:0]            wrS;
    logic [2:0]            rdS;
    logic                  rdAck;
    logic [15:0]           rdWord;
    logic [7:0]            pinOut;
    logic [7:0]            pinOutEnN;
    logic [7:0]            pullDownEn;
    logic [7:0]            dacChannelOn;
    logic                  refOn;
    logic                  adcOff;
  } iopdc_core_t;

  iopdc_link_t link_r;
  iopdc_link_t link_nxt;
  iopdc_core_t core_r;
  iopdc_core_t core_nxt;

  // ==========================================================================
  // clock crossing
  // a write word and a pointer are captured on linkClk and then held still;
  // only a toggle crosses, through three flops, so the core reads the held
  // word once the toggle has settled and never catches it mid-change.
  // the answer crosses back the same way, with its own toggle.

  // ==========================================================================
  // readback word for a pointer; unknown pointers read as zero
  function automatic logic [15:0] readback(
    input logic [7:0]            ptr,
    input iopdc_pkg::iopdc_cfg_t c,
    input logic [7:0]            inLevel
  );
    logic [15:0] word;
    word = 16'h0000;
    unique case (ptr)
      iopdc_pkg::PTR_IN_READ:   word = {8'h00, inLevel & c.inSel};
      iopdc_pkg::PTR_DAC_SEL:   word = {8'h00, c.dacSel};
      iopdc_pkg::PTR_PULL_DOWN: word = {8'h00, c.pullDownSel};
      iopdc_pkg::PTR_OUT_SEL:   word = {8'h00, c.outSel};
      iopdc_pkg::PTR_OUT_LEVEL: word = {8'h00, c.outLevel};
      iopdc_pkg::PTR_IN_SEL:    word = {8'h00, c.inSel};
      iopdc_pkg::PTR_PWR_CTRL:  word = {5'h00,
                                  c.pwr.globalPowerDown, c.pwr.refEnable,
                                  1'b0, c.pwr.dacChannelPowerDown};
      iopdc_pkg::PTR_OPEN_DRN:  word = {8'h00, c.openDrainSel};
      iopdc_pkg::PTR_THREE_ST:  word = {8'h00, c.threeStateSel};
      default:                  word = 16'h0000;
    endcase
    return word;
  endfunction : readback

  // ==========================================================================
  // per-pin decode of the registered configuration
  logic [7:0] pinDrive;
  logic [7:0] pinOutNxt;
  logic [7:0] pinOutEnNNxt;
  logic [7:0] pullDownNxt;
  logic [7:0] dacPowered;

  for (genvar n = 0; n < 8; n++) begin : g_pin
    logic outPin;
    logic floatPin;
    logic dacPin;
    logic openDrain;
    logic level;
    logic chanDown;

    assign outPin    = core_r.cfg.outSel[n];
    assign floatPin  = core_r.cfg.threeStateSel[n];
    assign dacPin    = core_r.cfg.dacSel[n];
    assign openDrain = core_r.cfg.openDrainSel[n];
    assign level     = core_r.cfg.outLevel[n];
    // a channel bit only counts on a dac pin; global power-down covers all
    assign chanDown  = core_r.cfg.pwr.dacChannelPowerDown[n]
                     | core_r.cfg.pwr.globalPowerDown;

    // three-state wins, then dac select, then general output
    assign pinDrive[n] = outPin & ~floatPin & ~dacPin;
    // open-drain pins never drive high, so their level reads as 0
    assign pinOutNxt[n] = level & ~openDrain;
    // an open-drain pin releases the line for a 1 and leans on the pull-up
    assign pinOutEnNNxt[n] = ~(pinDrive[n] & ~(openDrain & level));
    assign pullDownNxt[n] = core_r.cfg.pullDownSel[n] & ~floatPin
                          & ~pinDrive[n];
    // a powered-down channel floats; its data lives elsewhere and is kept
    assign dacPowered[n] = dacPin & ~chanDown
                         & ~floatPin;
  end

  // ==========================================================================
  // link side: pointer, msb and lsb capture
  always_comb begin
    iopdc_pkg::iopdc_phase_t ph;
    ph = frameStart ? iopdc_pkg::IOPDC_PH_PTR : link_r.phase;
    link_nxt = link_r;
    link_nxt.rstS1 = resetn;
    link_nxt.rstS2 = link_r.rstS1;
    link_nxt.ackS = {link_r.ackS[1:0], core_r.rdAck};
    link_nxt.phase = ph;
    if (byteValid) begin
      unique case (ph)
        iopdc_pkg::IOPDC_PH_PTR: begin
          link_nxt.ptr = byteData;
          // fetch the word this pointer names for a later read
          link_nxt.rdTog = ~link_r.rdTog;
          link_nxt.phase = iopdc_pkg::IOPDC_PH_MSB;
        end
        iopdc_pkg::IOPDC_PH_MSB: begin
          link_nxt.msb = byteData;
          link_nxt.phase = iopdc_pkg::IOPDC_PH_LSB;
        end
        iopdc_pkg::IOPDC_PH_LSB: begin
          link_nxt.wrWord = {link_r.ptr, link_r.msb, byteData};
          link_nxt.wrTog = ~link_r.wrTog;
          link_nxt.phase = iopdc_pkg::IOPDC_PH_DONE;
        end
        iopdc_pkg::IOPDC_PH_DONE: begin
          link_nxt.phase = iopdc_pkg::IOPDC_PH_DONE;
        end
      endcase
    end
    if (link_r.ackS[2] != link_r.ackS[1]) begin
      link_nxt.readWord = core_r.rdWord;
    end
    if (!link_r.rstS2) begin
      link_nxt = '0;
      link_nxt.rstS1 = resetn;
      link_nxt.rstS2 = link_r.rstS1;
      link_nxt.ackS = {link_r.ackS[1:0], core_r.rdAck};
    end
  end

  always_ff @(posedge linkClk) begin
    link_r <= link_nxt;
  end

  // ==========================================================================
  // core side: register file and pin control
  always_comb begin
    iopdc_pkg::iopdc_cfg_t c;
    iopdc_pkg::iopdc_wr_t  w;
    core_nxt = core_r;
    c = core_r.cfg;
    w = link_r.wrWord;
    core_nxt.inS1 = pinIn;
    core_nxt.inS2 = core_r.inS1;
    core_nxt.wrS = {core_r.wrS[1:0], link_r.wrTog};
    core_nxt.rdS = {core_r.rdS[1:0], link_r.rdTog};

    // a write is applied once its lsb has crossed over
    if (core_r.wrS[2] != core_r.wrS[1]) begin
      unique case (w.ptr)
        iopdc_pkg::PTR_DAC_SEL:   core_nxt.cfg.dacSel = w.data[7:0];
        iopdc_pkg::PTR_PULL_DOWN: core_nxt.cfg.pullDownSel = w.data[7:0];
        iopdc_pkg::PTR_OUT_SEL:   core_nxt.cfg.outSel = w.data[7:0];
        iopdc_pkg::PTR_OUT_LEVEL: begin
          // only pins set as outputs take the new level
          core_nxt.cfg.outLevel = (w.data[7:0] & c.outSel)
                                | (c.outLevel & ~c.outSel);
        end
        iopdc_pkg::PTR_IN_SEL:    core_nxt.cfg.inSel = w.data[7:0];
        iopdc_pkg::PTR_PWR_CTRL: begin
          core_nxt.cfg.pwr.globalPowerDown =
            w.data[iopdc_pkg::GLOBAL_PD_BIT];
          core_nxt.cfg.pwr.refEnable = w.data[iopdc_pkg::REF_EN_BIT];
          core_nxt.cfg.pwr.dacChannelPowerDown = w.data[7:0];
        end
        iopdc_pkg::PTR_OPEN_DRN:  core_nxt.cfg.openDrainSel = w.data[7:0];
        iopdc_pkg::PTR_THREE_ST:  core_nxt.cfg.threeStateSel = w.data[7:0];
        iopdc_pkg::PTR_SW_RESET: begin
          if (w.data == iopdc_pkg::SW_RESET_KEY) begin
            core_nxt.cfg = iopdc_pkg::CFG_RST;
          end
        end
        default: ;
      endcase
    end

    // readback word for the pointer last received
    if (core_r.rdS[2] != core_r.rdS[1]) begin
      core_nxt.rdAck = ~core_r.rdAck;
      core_nxt.rdWord = readback(link_r.ptr, c, core_r.inS2);
    end

    // pin drive from the per-pin decode
    core_nxt.pinOut = pinOutNxt;
    core_nxt.pinOutEnN = pinOutEnNNxt;
    core_nxt.pullDownEn = pullDownNxt;
    core_nxt.dacChannelOn = dacPowered;
    core_nxt.refOn = c.pwr.refEnable & ~c.pwr.globalPowerDown;
    core_nxt.adcOff = c.pwr.globalPowerDown;

    if (!resetn) begin
      core_nxt = '0;
      core_nxt.cfg = iopdc_pkg::CFG_RST;
      core_nxt.pinOutEnN = iopdc_pkg::DRIVE_OFF_N;
      core_nxt.pinOut = iopdc_pkg::PIN_RST;
    end
  end

  always_ff @(posedge ref_clk) begin
    core_r <= core_nxt;
  end

  // ==========================================================================
  // outputs
  assign readWord     = link_r.readWord;
  assign pinOut       = core_r.pinOut;
  assign pinOutEnN    = core_r.pinOutEnN;
  assign pullDownEn   = core_r.pullDownEn;
  assign dacChannelOn = core_r.dacChannelOn;
  assign refOn        = core_r.refOn;
  assign adcOff       = core_r.adcOff;

endmodule : iopdc_pin_config

// ### iopdc_pin_config_asserts.sv
// checks on the pin-control and readback outputs of the configuration block
// assumes linkClk is slower than ref_clk, so ref_clk sees every byte
module iopdc_pin_config_asserts (
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        linkClk,
  input wire logic        frameStart,
  input wire logic        byteValid,
  input wire logic [7:0]  byteData,
  input wire logic [15:0] readWord,
  input wire logic [7:0]  pinIn,
  input wire logic [7:0]  pinOut,
  input wire logic [7:0]  pinOutEnN,
  input wire logic [7:0]  pullDownEn,
  input wire logic [7:0]  dacChannelOn,
  input wire logic        refOn,
  input wire logic        adcOff
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ==========================================================================
  // ref_clk cycles since a link byte was last seen
  logic [7:0] quiet_r;
  always_ff @(posedge ref_clk) begin
    if (!resetn || byteValid) quiet_r <= 8'h00;
    else if (quiet_r != 8'hff) quiet_r <= quiet_r + 8'h01;
  end
  // ==========================================================================
  a_gpd_all_off: assert property (adcOff |-> !refOn && dacChannelOn == 8'h00)
    else $error("global power-down left something powered");
  a_pull_undriven: assert property ((pullDownEn & ~pinOutEnN) == 8'h00)
    else $error("pull-down on a driven pin");
  a_dac_undriven: assert property ((dacChannelOn & ~pinOutEnN) == 8'h00)
    else $error("dac channel on a driven pin");
  a_reset_values: assert property ($rose(resetn) |-> pinOutEnN == 8'hff &&
    pinOut == 8'h00 && pullDownEn == 8'h00 && !refOn && !adcOff)
    else $error("outputs not at defaults after reset");
  a_late_update: assert property ($changed({pinOut, pinOutEnN, pullDownEn,
    dacChannelOn, refOn, adcOff}) |-> quiet_r inside {[1:10]})
    else $error("pin outputs changed outside a write");
  a_atomic_apply: assert property ($changed(pinOutEnN) |=> $stable(pinOutEnN)[*3])
    else $error("drive enables changed in steps");
  a_read_late: assert property ($changed(readWord) |-> quiet_r <= 8'd14)
    else $error("readback changed without a fetch");
  a_read_upper: assert property (readWord[15:11] == 5'h00 && !readWord[8])
    else $error("reserved readback bits set");
  c_ref_on: cover property (refOn);
  c_gpd: cover property (adcOff);
  c_pull: cover property (pullDownEn != 8'h00 && pinOutEnN != 8'hff);
endmodule : iopdc_pin_config_asserts

bind iopdc_pin_config iopdc_pin_config_asserts iopdc_pin_config_asserts_i (
  .ref_clk, .resetn, .linkClk, .frameStart, .byteValid, .byteData, .readWord,
  .pinIn, .pinOut, .pinOutEnN, .pullDownEn, .dacChannelOn, .refOn, .adcOff);

// ### iopdc_pin_config_tb.sv
// self-checking bench for the pin configuration block
// assumes the link model frames every register access
module iopdc_pin_config_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        sampleReq = 1'b0;
  logic [7:0]  pinIn = 8'h00;
  logic        linkClk, frameStart, byteValid, refOn, adcOff, gpd, refEn;
  logic [7:0]  byteData, pinOut, pinOutEnN, pullDownEn, dacChannelOn;
  logic [7:0]  oSel, lvl, od, ts, pdSel, dacSel, inSel, pdCh;
  logic [15:0] readWord;
  logic [50:0] expQ[$];
  logic [50:0] e, got;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cycles = 0;
  always #50 ref_clk = ~ref_clk;
  iopdc_link_master iopdc_link_master_i (.linkClk, .frameStart, .byteValid,
    .byteData);
  iopdc_pin_config iopdc_pin_config_i (.ref_clk, .resetn, .linkClk,
    .frameStart, .byteValid, .byteData, .readWord, .pinIn, .pinOut,
    .pinOutEnN, .pullDownEn, .dacChannelOn, .refOn, .adcOff);
  // ==========================================================================
  function automatic logic [33:0] pinsExp();
    logic [7:0] drv;
    drv = oSel & ~ts & ~dacSel;
    return {drv & ~od & lvl, ~(drv & ~(od & lvl)),
      pdSel & ~drv & ~ts, dacSel & ~ts & ~pdCh & {8{~gpd}},
      refEn & ~gpd, gpd};
  endfunction : pinsExp
  task automatic chk(input logic rd, input logic [15:0] rw);
    @(posedge ref_clk);
    expQ.push_back({rd, rw, pinsExp()});
    sampleReq <= 1'b1;
    @(posedge ref_clk);
    sampleReq <= 1'b0;
  endtask : chk
  task automatic wr(input logic [7:0] p, input logic [15:0] w);
    case (p)
      iopdc_pkg::PTR_OUT_SEL:   oSel = w[7:0];
      iopdc_pkg::PTR_OUT_LEVEL: lvl = (lvl & ~oSel) | (w[7:0] & oSel);
      iopdc_pkg::PTR_OPEN_DRN:  od = w[7:0];
      iopdc_pkg::PTR_THREE_ST:  ts = w[7:0];
      iopdc_pkg::PTR_PULL_DOWN: pdSel = w[7:0];
      iopdc_pkg::PTR_DAC_SEL:   dacSel = w[7:0];
      iopdc_pkg::PTR_IN_SEL:    inSel = w[7:0];
      iopdc_pkg::PTR_PWR_CTRL:  {gpd, refEn, pdCh} = {w[10:9], w[7:0]};
      default: ;
    endcase
    iopdc_link_master_i.frame({p, w}, 3);
    chk(1'b0, 16'h0000);
  endtask : wr
  task automatic rd(input logic [7:0] p, input logic [15:0] x);
    iopdc_link_master_i.frame({p, 16'h0000}, 1);
    chk(1'b1, x);
  endtask : rd
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  // ==========================================================================
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      print_verdict();
    end
    if (sampleReq) begin
      e = expQ.pop_front();
      got = {e[50], e[50] ? readWord : e[49:34], pinOut & ~e[25:18],
        pinOutEnN, pullDownEn, dacChannelOn, refOn, adcOff};
      checks_done++;
      if (got !== e) begin
        miscompares++;
        $display("[FAIL] outputs exp %h got %h", e, got);
      end
    end
  end
  initial begin
    {oSel, lvl, od, ts, pdSel, dacSel, inSel, pdCh, gpd, refEn} = '0;
    void'($urandom(38820));
    fork
      iopdc_link_master_i.run(4);
    join_none
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    chk(1'b0, 16'h0000);
    $display("test reset done");
    repeat (4) begin
      wr(iopdc_pkg::PTR_OUT_SEL, {8'h00, 8'($urandom)});
      wr(iopdc_pkg::PTR_OPEN_DRN, {8'h00, 8'($urandom)});
      wr(iopdc_pkg::PTR_OUT_LEVEL, {8'h00, 8'($urandom)});
    end
    wr(iopdc_pkg::PTR_PULL_DOWN, 16'h00ff);
    wr(iopdc_pkg::PTR_THREE_ST, {8'h00, 8'($urandom)});
    iopdc_link_master_i.frame({iopdc_pkg::PTR_THREE_ST, 16'h0000}, 2);
    chk(1'b0, 16'h0000);
    $display("test outputs done");
    repeat (3) begin
      pinIn <= 8'($urandom);
      wr(iopdc_pkg::PTR_IN_SEL, {8'h00, 8'($urandom)});
      rd(iopdc_pkg::PTR_IN_READ, {8'h00, pinIn & inSel});
    end
    rd(iopdc_pkg::PTR_OUT_SEL, {8'h00, oSel});
    rd(8'h3f, 16'h0000);
    $display("test inputs done");
    wr(iopdc_pkg::PTR_PULL_DOWN, 16'h0000);
    wr(iopdc_pkg::PTR_DAC_SEL, 16'h00ff);
    wr(iopdc_pkg::PTR_PWR_CTRL, {8'h02, 8'($urandom)});
    wr(iopdc_pkg::PTR_PWR_CTRL, {8'h06, pdCh});
    wr(iopdc_pkg::PTR_PWR_CTRL, {8'h02, pdCh});
    $display("test power done");
    print_verdict();
  end
endmodule : iopdc_pin_config_tb

// ### iopdc_pkg.sv
// package for the eight-pin digital configuration block
// assumes a serial protocol engine hands over whole bytes on the link clock
package iopdc_pkg;

  // ==========================================================================
  // register pointers
  localparam logic [7:0] PTR_DAC_SEL   = 8'h05;
  localparam logic [7:0] PTR_PULL_DOWN = 8'h06;
  localparam logic [7:0] PTR_OUT_SEL   = 8'h08;
  localparam logic [7:0] PTR_OUT_LEVEL = 8'h09;
  localparam logic [7:0] PTR_IN_SEL    = 8'h0a;
  localparam logic [7:0] PTR_PWR_CTRL  = 8'h0b;
  localparam logic [7:0] PTR_OPEN_DRN  = 8'h0c;
  localparam logic [7:0] PTR_THREE_ST  = 8'h0d;
  localparam logic [7:0] PTR_SW_RESET  = 8'h0f;
  localparam logic [7:0] PTR_IN_READ   = 8'h60;

  // ==========================================================================
  // field positions and reset values
  localparam int          GLOBAL_PD_BIT = 10;
  localparam int          REF_EN_BIT    = 9;
  localparam logic [15:0] SW_RESET_KEY  = 16'h0dac;
  localparam logic [7:0]  PIN_RST       = 8'h00;
  localparam logic [7:0]  DRIVE_OFF_N   = 8'hff;

  // ==========================================================================
  // byte positions within a write frame
  typedef enum logic [1:0] {
    IOPDC_PH_PTR,
    IOPDC_PH_MSB,
    IOPDC_PH_LSB,
    IOPDC_PH_DONE
  } iopdc_phase_t;

  // one complete register write, handed from link to core
  typedef struct packed {
    logic [7:0]  ptr;
    logic [15:0] data;
  } iopdc_wr_t;

  // power-down and reference control fields
  typedef struct packed {
    logic       globalPowerDown;
    logic       refEnable;
    logic [7:0] dacChannelPowerDown;
  } iopdc_pwr_t;

  // pin configuration registers
  typedef struct packed {
    logic [7:0] dacSel;
    logic [7:0] pullDownSel;
    logic [7:0] outSel;
    logic [7:0] outLevel;
    logic [7:0] inSel;
    logic [7:0] openDrainSel;
    logic [7:0] threeStateSel;
    iopdc_pwr_t pwr;
  } iopdc_cfg_t;

  localparam iopdc_cfg_t CFG_RST = '0;

endpackage : iopdc_pkg
